// *** qei_chan.sv ***
// Encoder input channel: quadrature decode or two discrete lines
// How it works
// - Type 0 unused, 1 discrete lines, 2 quadrature encoder.
// - Both lines usable as discrete inputs only in type 1 discrete lines.
// - A rising before B counts up, direction positive.
// - B leading A counts down, direction negative.
// - No edge for stationary delay ms gives direction zero; default 100.
// - Nonzero forward/backward limits reset counter on reaching them.
// - Filter select 0 none, 1 moving, 2 repeating; off after reset.
// - Filter constant fixed at ten for encoder channels.
// - No filter passes latest raw value.
// - Moving average adds difference over constant each ms.
// - Repeating average sums N readings, outputs mean, restarts.
// - Value clamped into minimum and maximum range.
// - Fault when value below error minimum or above error maximum.
// - Discrete defaults: range and errors OFF to ON, no hysteresis.
// - Glitch filter select none, 111 ns, 1.78 us, 14.22 us.
// - Logic type only for discrete: normal, inverse, latched.
// - Normal: ON reads 1, OFF reads 0.
// - Inverse: ON reads 0, OFF reads 1.
// - Latched: state toggles at each OFF-to-ON change.
// - Active state 0 high, 1 low inverts line sense.
// - Bias select 0 off, 1 pull-up, 2 pull-down.
`timescale 1ns/1ps
`default_nettype none
module qei_chan #(
	parameter int W = 32,
	parameter int MSW = 16,
	parameter int TICK_CYC = qei_pkg::TICK_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic line_a,
	input wire logic line_b,
	input wire logic [1:0] in_type,
	input wire logic [1:0] filt_type,
	input wire logic [1:0] deb_sel,
	input wire logic [1:0] logic_type_a,
	input wire logic [1:0] logic_type_b,
	input wire logic active_low,
	input wire logic [MSW-1:0] deb_ms,
	input wire logic [MSW-1:0] stat_ms,
	input wire logic signed [W-1:0] lim_fwd,
	input wire logic signed [W-1:0] lim_bwd,
	input wire logic signed [W-1:0] rng_min,
	input wire logic signed [W-1:0] rng_max,
	input wire logic signed [W-1:0] err_min,
	input wire logic signed [W-1:0] err_max,
	input wire logic [1:0] bias_sel,
	output logic signed [W-1:0] count,
	output qei_pkg::qei_dir_e dir,
	output logic state_a,
	output logic state_b,
	output logic signed [W-1:0] value,
	output logic fault,
	output logic pull_up_en,
	output logic pull_dn_en
);
	import qei_pkg::*;

	function automatic logic [1:0] qstep(input logic [1:0] p,
		input logic [1:0] c);
		logic [3:0] t;
		t = {p, c};
		// Bit 0 is line A; A moving first counts up
		case (t)
			4'b0001, 4'b0111, 4'b1110, 4'b1000: qstep = QSTEP_UP;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: qstep = QSTEP_DN;
			default: qstep = QSTEP_NONE;
		endcase
	endfunction

	// Reset release
	logic rs1_reg, rs2_reg, rst_n;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs1_reg <= 1'b0;
			rs2_reg <= 1'b0;
		end else begin
			rs1_reg <= 1'b1;
			rs2_reg <= rs1_reg;
		end
	end
	assign rst_n = rs2_reg;

	// Millisecond tick
	localparam int TW = $clog2(TICK_CYC + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
	logic [TW-1:0] tc_reg, tc_next;
	logic tick_reg, tick_next;
	always_comb begin
		tick_next = (tc_reg == TICK_LAST);
		tc_next = tick_next ? '0 : tc_reg + 1'b1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tc_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tc_reg <= tc_next;
			tick_reg <= tick_next;
		end
	end

	// Line conditioning
	logic [1:0] raw, filt;
	logic disc;
	assign raw = {line_b, line_a};
	assign disc = (in_type == TYPE_DISC);
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_line
			qei_deb #(.MSW(MSW)) u_deb (
				.clk(clk),
				.rst_n(rst_n),
				.din(raw[gi]),
				.sel(deb_sel),
				.tick(tick_reg),
				.ms_en(disc),
				.ms(deb_ms),
				.dout(filt[gi])
			);
		end
	endgenerate

	// Discrete logic per line
	logic [1:0] on, on_d_reg, on_d_next, st_reg, st_next;
	logic [1:0] ltype [2];
	assign ltype[0] = logic_type_a;
	assign ltype[1] = logic_type_b;
	assign on = filt ^ {2{active_low}};
	generate
		for (gi = 0; gi < 2; gi++) begin : g_logic
			always_comb begin
				on_d_next[gi] = on[gi];
				st_next[gi] = 1'b0;
				if (disc) begin
					case (ltype[gi])
						LOG_NORM: st_next[gi] = on[gi];
						LOG_INV: st_next[gi] = ~on[gi];
						LOG_LAT: st_next[gi] = st_reg[gi]
							^ (on[gi] & ~on_d_reg[gi]);
						default: st_next[gi] = on[gi];
					endcase
				end
			end
		end
	endgenerate
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			on_d_reg <= 2'b00;
			st_reg <= 2'b00;
		end else begin
			on_d_reg <= on_d_next;
			st_reg <= st_next;
		end
	end

	// Quadrature decode
	logic enc;
	logic [1:0] qp_reg, qp_next, step;
	logic signed [W-1:0] cnt_reg, cnt_next;
	qei_dir_e dir_reg, dir_next;
	logic [MSW-1:0] idle_reg, idle_next;
	assign enc = (in_type == TYPE_ENC);
	assign step = enc ? qstep(qp_reg, filt) : QSTEP_NONE;
	always_comb begin
		qp_next = filt;
		cnt_next = cnt_reg;
		dir_next = dir_reg;
		idle_next = idle_reg;
		if (step == QSTEP_UP) begin
			cnt_next = cnt_reg + 1'b1;
			dir_next = DIR_POS;
		end
		if (step == QSTEP_DN) begin
			cnt_next = cnt_reg - 1'b1;
			dir_next = DIR_NEG;
		end
		if (lim_fwd != '0 && step == QSTEP_UP && cnt_next == lim_fwd) begin
			cnt_next = '0;
		end
		if (lim_bwd != '0 && step == QSTEP_DN && cnt_next == lim_bwd) begin
			cnt_next = '0;
		end
		if (!enc || qp_reg != filt) begin
			idle_next = '0;
		end else if (tick_reg && idle_reg != stat_ms) begin
			idle_next = idle_reg + 1'b1;
		end
		if (!enc || idle_next >= stat_ms) begin
			dir_next = DIR_STAT;
		end
		if (!enc) begin
			cnt_next = '0;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qp_reg <= 2'b00;
			cnt_reg <= '0;
			dir_reg <= DIR_STAT;
			idle_reg <= '0;
		end else begin
			qp_reg <= qp_next;
			cnt_reg <= cnt_next;
			dir_reg <= dir_next;
			idle_reg <= idle_next;
		end
	end

	logic signed [W-1:0] meas, flt_out;
	assign meas = enc ? cnt_reg : W'($unsigned(st_reg[0]));
	qei_flt #(.W(W)) u_flt (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick_reg),
		.mode(filt_type),
		.din(meas),
		.dout(flt_out)
	);

	// Range, fault and output registers
	logic signed [W-1:0] rmin, rmax, emin, emax, val_reg, val_next;
	logic flt_reg, flt_next;
	logic [1:0] bias_reg, bias_next;
	always_comb begin
		rmin = disc ? '0 : rng_min;
		rmax = disc ? W'(1) : rng_max;
		emin = disc ? '0 : err_min;
		emax = disc ? W'(1) : err_max;
		if (flt_out < rmin) begin
			val_next = rmin;
		end else if (flt_out > rmax) begin
			val_next = rmax;
		end else begin
			val_next = flt_out;
		end
		flt_next = (in_type != TYPE_OFF) && (flt_out < emin || flt_out > emax);
		if (in_type == TYPE_OFF) begin
			val_next = '0;
		end
		case (bias_sel)
			BIAS_UP: bias_next = 2'b01;
			BIAS_DN: bias_next = 2'b10;
			default: bias_next = 2'b00;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			val_reg <= '0;
			flt_reg <= 1'b0;
			bias_reg <= 2'b00;
		end else begin
			val_reg <= val_next;
			flt_reg <= flt_next;
			bias_reg <= bias_next;
		end
	end

	assign count = cnt_reg;
	assign dir = dir_reg;
	assign state_a = st_reg[0];
	assign state_b = st_reg[1];
	assign value = val_reg;
	assign fault = flt_reg;
	assign pull_up_en = bias_reg[0];
	assign pull_dn_en = bias_reg[1];

	sequence s_a_lead;
		qp_reg == 2'b00 && filt == 2'b01;
	endsequence
	sequence s_b_lead;
		qp_reg == 2'b00 && filt == 2'b10;
	endsequence

	AST_UP: assert property (@(posedge clk) disable iff (!rst_n)
		enc ##0 s_a_lead |=> dir_reg == DIR_POS
			&& (cnt_reg == $past(cnt_reg) + 1 || cnt_reg == '0))
		else $error("A leading did not count up");
	AST_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
		enc ##0 s_b_lead |=> dir_reg == DIR_NEG
			&& (cnt_reg == $past(cnt_reg) - 1 || cnt_reg == '0))
		else $error("B leading did not count down");
	AST_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
		enc && lim_fwd != '0 ##0 step == QSTEP_UP
			&& cnt_reg + 1 == lim_fwd |=> cnt_reg == '0)
		else $error("forward limit did not reset counter");
	AST_STAT: assert property (@(posedge clk) disable iff (!rst_n)
		enc && stat_ms != '0 && idle_reg >= stat_ms |-> dir_reg == DIR_STAT)
		else $error("direction not stationary after idle delay");
	AST_NORM: assert property (@(posedge clk) disable iff (!rst_n)
		disc && logic_type_a == LOG_NORM |=> st_reg[0] == $past(on[0]))
		else $error("normal logic state wrong");
	AST_INV: assert property (@(posedge clk) disable iff (!rst_n)
		disc && logic_type_a == LOG_INV |=> st_reg[0] == !$past(on[0]))
		else $error("inverse logic state wrong");
	AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
		disc && logic_type_a == LOG_LAT && on[0] && !on_d_reg[0]
			|=> st_reg[0] != $past(st_reg[0]))
		else $error("latched logic did not toggle");
	AST_CLAMP: assert property (@(posedge clk) disable iff (!rst_n)
		enc && rng_min <= rng_max |=> val_reg >= $past(rng_min)
			&& val_reg <= $past(rng_max))
		else $error("value outside range limits");
	AST_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
		enc && flt_out > err_max |=> flt_reg)
		else $error("fault not raised above error maximum");
	AST_BIAS: assert property (@(posedge clk) disable iff (!rst_n)
		##1 !(pull_up_en && pull_dn_en))
		else $error("pull-up and pull-down both on");
	AST_LIMIT_BWD: assert property (@(posedge clk) disable iff (!rst_n)
		enc && lim_bwd != '0 ##0 step == QSTEP_DN
			&& cnt_reg - 1 == lim_bwd |=> cnt_reg == '0)
		else $error("backward limit did not reset counter");
	AST_FAULT_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		enc && flt_out < err_min |=> flt_reg)
		else $error("fault not raised below error minimum");
	AST_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		in_type == TYPE_OFF |=> value == '0 && !fault)
		else $error("unused channel reports a value or fault");
	AST_NOT_ENC: assert property (@(posedge clk) disable iff (!rst_n)
		!enc |=> count == '0 && dir == DIR_STAT)
		else $error("count or direction moved while not decoding");
	AST_NOT_DISC: assert property (@(posedge clk) disable iff (!rst_n)
		!disc |=> !state_a && !state_b)
		else $error("discrete state set while not discrete");
endmodule
`default_nettype wire

// *** qei_pkg.sv ***
// Shared constants and types for the quadrature encoder input channel
package qei_pkg;
	localparam logic [1:0] TYPE_OFF = 2'h0;
	localparam logic [1:0] TYPE_DISC = 2'h1;
	localparam logic [1:0] TYPE_ENC = 2'h2;
	localparam logic [1:0] FLT_NONE = 2'h0;
	localparam logic [1:0] FLT_MOV = 2'h1;
	localparam logic [1:0] FLT_REP = 2'h2;
	localparam logic [1:0] LOG_NORM = 2'h0;
	localparam logic [1:0] LOG_INV = 2'h1;
	localparam logic [1:0] LOG_LAT = 2'h2;
	localparam logic [1:0] BIAS_OFF = 2'h0;
	localparam logic [1:0] BIAS_UP = 2'h1;
	localparam logic [1:0] BIAS_DN = 2'h2;
	localparam int CLK_NS = 10;
	localparam int DEB1_NS = 111;
	localparam int DEB2_NS = 1780;
	localparam int DEB3_NS = 14220;
	localparam logic [10:0] DEB1_CYC = 11'((DEB1_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [10:0] DEB2_CYC = 11'((DEB2_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [10:0] DEB3_CYC = 11'((DEB3_NS + CLK_NS - 1) / CLK_NS);
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [15:0] STAT_MS_DEF = 16'h0064;
	localparam logic [3:0] FILT_K = 4'hA;
	localparam logic [1:0] QSTEP_NONE = 2'h0;
	localparam logic [1:0] QSTEP_UP = 2'h1;
	localparam logic [1:0] QSTEP_DN = 2'h3;
	typedef enum logic [1:0] {
		DIR_STAT = 2'b00,
		DIR_POS = 2'b01,
		DIR_NEG = 2'b10
	} qei_dir_e;
endpackage

// *** qei_deb.sv ***
// Two-stage line conditioner: cycle glitch filter, then ms stability time
`timescale 1ns/1ps
`default_nettype none
module qei_deb #(
	parameter int MSW = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	input wire logic [1:0] sel,
	input wire logic tick,
	input wire logic ms_en,
	input wire logic [MSW-1:0] ms,
	output logic dout
);
	import qei_pkg::*;
	logic [10:0] c1_reg, c1_next, lim;
	logic f1_reg, f1_next, f2_reg, f2_next;
	logic [MSW-1:0] c2_reg, c2_next;

	always_comb begin
		case (sel)
			2'h1: lim = DEB1_CYC;
			2'h2: lim = DEB2_CYC;
			2'h3: lim = DEB3_CYC;
			default: lim = 11'h001;
		endcase
		c1_next = 11'h000;
		f1_next = f1_reg;
		if (sel == 2'h0) begin
			f1_next = din;
		end else if (din != f1_reg) begin
			c1_next = c1_reg + 11'h001;
			if (c1_next >= lim) begin
				f1_next = din;
				c1_next = 11'h000;
			end
		end
		c2_next = c2_reg;
		f2_next = f2_reg;
		if (!ms_en || ms == '0) begin
			f2_next = f1_reg;
			c2_next = '0;
		end else if (f1_reg == f2_reg) begin
			c2_next = '0;
		end else if (tick) begin
			c2_next = c2_reg + 1'b1;
			if (c2_next >= ms) begin
				f2_next = f1_reg;
				c2_next = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c1_reg <= 11'h000;
			f1_reg <= 1'b0;
			c2_reg <= '0;
			f2_reg <= 1'b0;
		end else begin
			c1_reg <= c1_next;
			f1_reg <= f1_next;
			c2_reg <= c2_next;
			f2_reg <= f2_next;
		end
	end
	assign dout = f2_reg;

	AST_DEB_GLITCH: assert property (@(posedge clk) disable iff (!rst_n)
		sel == 2'h1 && $changed(f1_reg) |-> $past(din, 1) == f1_reg
			&& $past(din, 11) == f1_reg)
		else $error("short pulse passed the glitch filter");
	AST_DEB_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
		ms_en && ms != '0 && $changed(f2_reg) |-> $past(tick))
		else $error("debounced level moved off the ms tick");
endmodule
`default_nettype wire

// *** qei_flt.sv ***
// Data filter: none, moving average or repeating average per ms tick
`timescale 1ns/1ps
`default_nettype none
module qei_flt #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic [1:0] mode,
	input wire logic signed [W-1:0] din,
	output logic signed [W-1:0] dout
);
	import qei_pkg::*;
	localparam logic signed [W+4:0] K = (W+5)'(FILT_K);
	logic signed [W-1:0] val_reg, val_next;
	logic signed [W+4:0] acc_reg, acc_next, diff;
	logic [3:0] n_reg, n_next;

	always_comb begin
		val_next = val_reg;
		acc_next = acc_reg;
		n_next = n_reg;
		diff = (W+5)'(din) - (W+5)'(val_reg);
		if (tick) begin
			case (mode)
				FLT_NONE: val_next = din;
				FLT_MOV: val_next = W'((W+5)'(val_reg) + diff / K);
				FLT_REP: begin
					acc_next = acc_reg + (W+5)'(din);
					n_next = n_reg + 4'h1;
					if (n_next == FILT_K) begin
						val_next = W'(acc_next / K);
						acc_next = '0;
						n_next = 4'h0;
					end
				end
				default: val_next = din;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			val_reg <= '0;
			acc_reg <= '0;
			n_reg <= 4'h0;
		end else begin
			val_reg <= val_next;
			acc_reg <= acc_next;
			n_reg <= n_next;
		end
	end
	assign dout = val_reg;

	AST_FLT_NONE: assert property (@(posedge clk) disable iff (!rst_n)
		tick && mode == FLT_NONE |=> val_reg == $past(din))
		else $error("unfiltered value is not the latest input");
	AST_FLT_REP: assert property (@(posedge clk) disable iff (!rst_n)
		tick && mode == FLT_REP && n_reg == FILT_K - 4'h1
			|=> n_reg == 4'h0 && acc_reg == '0)
		else $error("repeating average did not restart after N readings");
endmodule
`default_nettype wire

// *** qei_enc_model.sv ***
// Encoder and switch model driving the two channel lines
`timescale 1ns/1ps
`default_nettype none
module qei_enc_model (
	input wire logic clk,
	output logic line_a,
	output logic line_b
);
	initial begin
		line_a = 1'h0;
		line_b = 1'h0;
	end
	// One x4 step, held four cycles
	task automatic step(input logic fwd);
		@(posedge clk);
		if ((line_a == line_b) == fwd) begin
			line_a <= ~line_a;
		end else begin
			line_b <= ~line_b;
		end
		repeat (4) @(posedge clk);
	endtask
	task automatic set_lines(input logic a, input logic b);
		@(posedge clk);
		line_a <= a;
		line_b <= b;
	endtask
	// Line A held inverted for n cycles
	task automatic pulse_a(input int n);
		@(posedge clk);
		line_a <= ~line_a;
		repeat (n) @(posedge clk);
		line_a <= ~line_a;
	endtask
endmodule
`default_nettype wire

// *** qei_chan_bench.sv ***
// Self-checking bench for the encoder input channel
`timescale 1ns/1ps
`default_nettype none
module qei_chan_bench;
	import qei_pkg::*;
	localparam int TCK = 20;
	logic clk, nrst, line_a, line_b, active_low;
	logic [1:0] in_type, filt_type, deb_sel, lt_a, lt_b, bias_sel;
	logic [15:0] deb_ms, stat_ms;
	logic signed [31:0] lim_fwd, lim_bwd, rng_min, rng_max, err_min, err_max;
	logic signed [31:0] count, value;
	qei_dir_e dir;
	logic state_a, state_b, fault, pull_up_en, pull_dn_en;
	int n_mismatch = 0;
	int checks = 0;
	qei_enc_model qei_enc_model_inst (.clk(clk), .line_a(line_a),
		.line_b(line_b));
	qei_chan #(.TICK_CYC(TCK)) qei_chan_inst (.clk(clk), .nrst(nrst),
		.line_a(line_a), .line_b(line_b), .in_type(in_type),
		.filt_type(filt_type), .deb_sel(deb_sel), .logic_type_a(lt_a),
		.logic_type_b(lt_b), .active_low(active_low), .deb_ms(deb_ms),
		.stat_ms(stat_ms), .lim_fwd(lim_fwd), .lim_bwd(lim_bwd),
		.rng_min(rng_min), .rng_max(rng_max), .err_min(err_min),
		.err_max(err_max), .bias_sel(bias_sel), .count(count), .dir(dir),
		.state_a(state_a), .state_b(state_b), .value(value),
		.fault(fault), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic end_of_test();
		if (n_mismatch == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic steps(input int n, input logic fwd);
		for (int i = 0; i < n; i++) begin
			qei_enc_model_inst.step(fwd);
		end
		cyc(4);
	endtask
	task automatic chk_disc(input logic ea, input logic eb);
		cyc(8);
		chk("state_a", {31'h0, ea}, {31'h0, state_a});
		chk("state_b", {31'h0, eb}, {31'h0, state_b});
	endtask
	initial begin
		nrst = 1'h0;
		in_type = TYPE_ENC;
		filt_type = FLT_MOV;
		deb_sel = 2'h0;
		lt_a = LOG_NORM;
		lt_b = LOG_INV;
		active_low = 1'h0;
		deb_ms = 16'h0000;
		stat_ms = 16'h0002;
		lim_fwd = 32'sh0;
		lim_bwd = 32'sh0;
		rng_min = -32'sh64;
		rng_max = 32'sh64;
		err_min = -32'shC8;
		err_max = 32'shC8;
		bias_sel = BIAS_OFF;
		cyc(20);
		nrst <= 1'h1;
		cyc(5);
		chk("value", 32'h0, value);
		chk("dir", 32'h0, {30'h0, dir});
		steps(12, 1'h1);
		chk("count", 32'h0000000C, count);
		chk("dir", {30'h0, DIR_POS}, {30'h0, dir});
		cyc(30 * TCK);
		chk("value", 32'h00000003, value);
		filt_type <= FLT_REP;
		cyc(25 * TCK);
		chk("value", 32'h0000000C, value);
		filt_type <= FLT_NONE;
		rng_max <= 32'shA;
		err_max <= 32'shB;
		cyc(3 * TCK);
		chk("value", 32'h0000000A, value);
		chk("fault", 32'h1, {31'h0, fault});
		err_max <= 32'sh14;
		cyc(3 * TCK);
		chk("fault", 32'h0, {31'h0, fault});
		steps(2, 1'h0);
		chk("count", 32'h0000000A, count);
		chk("dir", {30'h0, DIR_NEG}, {30'h0, dir});
		for (int i = 0; i <= 5 * TCK && dir !== DIR_STAT; i++) begin
			cyc(1);
		end
		chk("dir", {30'h0, DIR_STAT}, {30'h0, dir});
		if (dir !== DIR_STAT) begin
			end_of_test();
		end
		lim_fwd <= 32'shD;
		lim_bwd <= -32'sh2;
		steps(3, 1'h1);
		chk("count", 32'h0, count);
		steps(2, 1'h0);
		chk("count", 32'h0, count);
		in_type <= TYPE_DISC;
		qei_enc_model_inst.set_lines(1'h1, 1'h1);
		chk_disc(1'h1, 1'h0);
		active_low <= 1'h1;
		chk_disc(1'h0, 1'h1);
		active_low <= 1'h0;
		lt_a <= LOG_LAT;
		qei_enc_model_inst.set_lines(1'h0, 1'h0);
		cyc(8);
		begin
			logic s0;
			s0 = state_a;
			qei_enc_model_inst.set_lines(1'h1, 1'h0);
			chk_disc(~s0, 1'h1);
			qei_enc_model_inst.set_lines(1'h0, 1'h0);
			chk_disc(~s0, 1'h1);
			qei_enc_model_inst.set_lines(1'h1, 1'h0);
			chk_disc(s0, 1'h1);
		end
		lt_a <= LOG_NORM;
		deb_sel <= 2'h1;
		cyc(30);
		qei_enc_model_inst.pulse_a(5);
		cyc(30);
		chk("state_a", 32'h1, {31'h0, state_a});
		qei_enc_model_inst.set_lines(1'h0, 1'h0);
		cyc(30);
		chk("state_a", 32'h0, {31'h0, state_a});
		deb_sel <= 2'h0;
		deb_ms <= 16'h0002;
		qei_enc_model_inst.pulse_a(10);
		cyc(4 * TCK);
		chk("state_a", 32'h0, {31'h0, state_a});
		qei_enc_model_inst.set_lines(1'h1, 1'h0);
		cyc(5 * TCK);
		chk("state_a", 32'h1, {31'h0, state_a});
		bias_sel <= BIAS_UP;
		cyc(4);
		chk("bias", 32'h2, {30'h0, pull_up_en, pull_dn_en});
		bias_sel <= BIAS_DN;
		cyc(4);
		chk("bias", 32'h1, {30'h0, pull_up_en, pull_dn_en});
		bias_sel <= BIAS_OFF;
		in_type <= TYPE_OFF;
		cyc(8);
		chk("bias", 32'h0, {30'h0, pull_up_en, pull_dn_en});
		chk("off", 32'h0, {count[29:0], state_a, state_b});
		chk("off value", 32'h0, value);
		chk("off fault", 32'h0, {31'h0, fault});
		end_of_test();
	end
endmodule
`default_nettype wire
